// >>> inc/sbns_defines.svh
// Constants for the subtract-with-borrow and nibble-swap datapath.
`ifndef SBNS_DEFINES_SVH
`define SBNS_DEFINES_SVH
`define SBNS_OPC_MSB 15
`define SBNS_OPC_LSB 10
`define SBNS_SUBB_OPC 6'h16
`define SBNS_SWAP_OPC 6'h0e
`define SBNS_DEST_BIT 9
`define SBNS_ACC_BIT 8
`define SBNS_ACCESS_SPLIT 8'h80
`define SBNS_ACCESS_HI_BANK 4'hf
`define SBNS_ACCESS_LO_BANK 4'h0
`define SBNS_FLAG_C 0
`define SBNS_FLAG_DC 1
`define SBNS_FLAG_Z 2
`define SBNS_FLAG_OV 3
`define SBNS_FLAG_N 4
`define SBNS_WREG_RST 8'h00
`define SBNS_FLAGS_RST 5'h00
`endif

// >>> inc/sbns_pkg.sv
// Types for the subtract-with-borrow and nibble-swap datapath.
package sbns_pkg;
	typedef enum logic [1:0] {SBNS_OP_NONE, SBNS_OP_SUBB, SBNS_OP_SWAP} sbns_op_t;
	typedef enum logic [1:0] {SBNS_Q1, SBNS_Q2, SBNS_Q3, SBNS_Q4} sbns_phase_t;
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} sbns_flags_t;
	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] data;
	} sbns_fwr_t;
endpackage

// >>> src/sbns_alu.sv
// Subtract-with-borrow arithmetic unit with flag generation.
`timescale 1ns/1ps
`include "sbns_defines.svh"
module sbns_alu
	import sbns_pkg::*;
#(
	parameter int W = 8
)(
	input wire logic [W-1:0] a_in,
	input wire logic [W-1:0] b_in,
	input wire logic c_in,
	output logic [W-1:0] res,
	output sbns_flags_t flags
);
	logic [W:0] sum;
	logic [4:0] lo;
	// =========================================
	// Arithmetic
	// Two's complement subtract.
	always_comb
	begin
		sum = {1'b0, a_in} + {1'b0, ~b_in} + {{W{1'b0}}, c_in};
		lo = {1'b0, a_in[3:0]} + {1'b0, ~b_in[3:0]} + {4'h0, c_in};
		res = sum[W-1:0];
		flags.c = sum[W];
		flags.dc = lo[4];
		flags.z = (sum[W-1:0] == '0);
		flags.n = sum[W-1];
		flags.ov = (a_in[W-1] != b_in[W-1]) && (sum[W-1] != a_in[W-1]);
	end
endmodule

// >>> src/sbns_exec.sv
// Execution datapath for the subtract-with-borrow and nibble-swap instructions.
`timescale 1ns/1ps
`include "sbns_defines.svh"
// Operation
// - Subtract-with-borrow: file minus accumulator minus inverted carry, sets five flags.
// - Subtract result goes to accumulator when dest is 0, else file.
// - Access bit 0 uses the access bank and ignores the bank pointer.
// - Access bit 1 forms the address from the bank-select pointer.
// - Nibble swap exchanges the two nibbles and leaves flags unchanged.
// - Nibble swap is recognised by its fixed upper six bits.
// - Swapped byte goes to accumulator when dest is 0, else file.
module sbns_exec
	import sbns_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [15:0] instr,
	input wire logic instr_valid,
	input wire logic [3:0] bank_select_pointer,
	input wire logic [7:0] file_rdata,
	output logic [11:0] file_raddr,
	output sbns_fwr_t file_wr,
	output logic [7:0] wreg,
	output sbns_flags_t flags,
	output sbns_phase_t phase,
	output logic busy,
	output logic done
);
	sbns_phase_t phase_q, phase_d;
	sbns_op_t op_q, op_d;
	logic dest_q, dest_d;
	logic [11:0] addr_q, addr_d;
	logic [7:0] opnd_q, opnd_d;
	logic [7:0] res_q, res_d;
	sbns_flags_t fres_q, fres_d;
	logic [7:0] wreg_q, wreg_d;
	sbns_flags_t flags_q, flags_d;
	sbns_fwr_t wr_q, wr_d;
	logic done_q, done_d;
	logic [7:0] alu_res;
	sbns_flags_t alu_flags;

	// =========================================
	// Decode helpers
	function automatic sbns_op_t decode_op(input logic [15:0] ins);
		if (ins[`SBNS_OPC_MSB:`SBNS_OPC_LSB] == `SBNS_SUBB_OPC)
			return SBNS_OP_SUBB;
		else if (ins[`SBNS_OPC_MSB:`SBNS_OPC_LSB] == `SBNS_SWAP_OPC)
			return SBNS_OP_SWAP;
		return SBNS_OP_NONE;
	endfunction

	function automatic logic [11:0] form_addr(input logic acc, input logic [3:0] bsp,
		input logic [7:0] f);
		// Access bank overrides the bank pointer.
		if (!acc)
			return {(f < `SBNS_ACCESS_SPLIT) ? `SBNS_ACCESS_LO_BANK : `SBNS_ACCESS_HI_BANK, f};
		// Bank pointer forms the upper address.
		return {bsp, f};
	endfunction

	sbns_alu #(.W(8)) u_alu (
		.a_in(opnd_q),
		.b_in(wreg_q),
		.c_in(flags_q.c),
		.res(alu_res),
		.flags(alu_flags)
	);

	// =========================================
	// Phase sequencer and datapath
	always_comb
	begin
		phase_d = phase_q;
		op_d = op_q;
		dest_d = dest_q;
		addr_d = addr_q;
		opnd_d = opnd_q;
		res_d = res_q;
		fres_d = fres_q;
		wreg_d = wreg_q;
		flags_d = flags_q;
		wr_d = '0;
		done_d = 1'b0;
		unique case (phase_q)
			SBNS_Q1:
			begin
				if (instr_valid && decode_op(instr) != SBNS_OP_NONE)
				begin
					op_d = decode_op(instr);
					dest_d = instr[`SBNS_DEST_BIT];
					addr_d = form_addr(instr[`SBNS_ACC_BIT], bank_select_pointer, instr[7:0]);
					phase_d = SBNS_Q2;
				end
			end
			SBNS_Q2:
			begin
				opnd_d = file_rdata;
				phase_d = SBNS_Q3;
			end
			SBNS_Q3:
			begin
				if (op_q == SBNS_OP_SUBB)
				begin
					res_d = alu_res;
					fres_d = alu_flags;
				end
				else
				begin
					res_d = {opnd_q[3:0], opnd_q[7:4]};
					fres_d = flags_q;
				end
				phase_d = SBNS_Q4;
			end
			SBNS_Q4:
			begin
				// Arithmetic flags update on subtract only.
				if (op_q == SBNS_OP_SUBB)
					flags_d = fres_q;
				if (!dest_q)
					wreg_d = res_q;
				else
				begin
					wr_d.we = 1'b1;
					wr_d.addr = addr_q;
					wr_d.data = res_q;
				end
				done_d = 1'b1;
				phase_d = SBNS_Q1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			phase_q <= SBNS_Q1;
			op_q <= SBNS_OP_NONE;
			dest_q <= 1'b0;
			addr_q <= 12'h000;
			opnd_q <= 8'h00;
			res_q <= 8'h00;
			fres_q <= `SBNS_FLAGS_RST;
			wreg_q <= `SBNS_WREG_RST;
			flags_q <= `SBNS_FLAGS_RST;
			wr_q <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			phase_q <= phase_d;
			op_q <= op_d;
			dest_q <= dest_d;
			addr_q <= addr_d;
			opnd_q <= opnd_d;
			res_q <= res_d;
			fres_q <= fres_d;
			wreg_q <= wreg_d;
			flags_q <= flags_d;
			wr_q <= wr_d;
			done_q <= done_d;
		end
	end

	assign file_raddr = addr_q;
	assign file_wr = wr_q;
	assign wreg = wreg_q;
	assign flags = flags_q;
	assign phase = phase_q;
	assign busy = (phase_q != SBNS_Q1);
	assign done = done_q;

	// =========================================
	// Assertions
	sequence s_cycle;
		phase_q == SBNS_Q2 ##1 phase_q == SBNS_Q3 ##1 phase_q == SBNS_Q4 ##1 phase_q == SBNS_Q1;
	endsequence

	a_phase_order: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q1 && phase_d == SBNS_Q2) |=> s_cycle)
		else $error("phase order broken");
	a_swap_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q4 && op_q == SBNS_OP_SWAP) |=> flags_q == $past(flags_q))
		else $error("swap changed flags");
	a_swap_data: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q3 && op_q == SBNS_OP_SWAP) |=>
		res_q == {$past(opnd_q[3:0]), $past(opnd_q[7:4])})
		else $error("swap data wrong");
	a_subb_result: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q3 && op_q == SBNS_OP_SUBB) |=>
		res_q == 8'(($past(opnd_q) - $past(wreg_q)) - {7'h00, ~$past(flags_q.c)}))
		else $error("subtract result wrong");
	a_flag_zn: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q4 && op_q == SBNS_OP_SUBB) |=>
		flags_q.z == ($past(res_q) == 8'h00) && flags_q.n == $past(res_q[7]))
		else $error("zero or negative flag wrong");
	a_dest_w: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q4 && !dest_q) |=> wreg_q == $past(res_q) && !file_wr.we)
		else $error("accumulator destination wrong");
	a_dest_f: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q4 && dest_q) |=> file_wr.we && file_wr.data == $past(res_q)
		&& wreg_q == $past(wreg_q))
		else $error("file destination wrong");
	a_bank_ptr: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q1 && phase_d == SBNS_Q2 && instr[`SBNS_ACC_BIT]) |=>
		file_raddr == {$past(bank_select_pointer), $past(instr[7:0])})
		else $error("banked address wrong");
	a_access_bank: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q1 && phase_d == SBNS_Q2 && !instr[`SBNS_ACC_BIT]) |=>
		file_raddr[11:8] == (file_raddr[7] ? `SBNS_ACCESS_HI_BANK : `SBNS_ACCESS_LO_BANK))
		else $error("access bank address wrong");
	a_decode_ops: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q1 && instr_valid && instr[15:10] == `SBNS_SWAP_OPC) |=>
		op_q == SBNS_OP_SWAP && phase_q == SBNS_Q2)
		else $error("swap not decoded");
	a_decode_subb: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_q == SBNS_Q1 && instr_valid && instr[15:10] == `SBNS_SUBB_OPC) |=>
		op_q == SBNS_OP_SUBB && phase_q == SBNS_Q2)
		else $error("subtract not decoded");
endmodule

// >>> bench/sbns_exec_test.sv
// Self-checking bench for the subtract-with-borrow and nibble-swap datapath.
`timescale 1ns/1ps
`include "sbns_defines.svh"
module sbns_exec_test
	import sbns_pkg::*;
;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic instr_valid = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [3:0] bank_select_pointer = 4'h0;
	logic [7:0] file_rdata = 8'h00;
	logic [11:0] file_raddr;
	sbns_fwr_t file_wr;
	sbns_fwr_t wr_seen;
	logic [7:0] wreg;
	sbns_flags_t flags;
	sbns_phase_t phase;
	logic busy;
	logic done;
	int fail_count = 0;
	int checked = 0;
	sbns_exec dut (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.instr(instr),
		.instr_valid(instr_valid),
		.bank_select_pointer(bank_select_pointer),
		.file_rdata(file_rdata),
		.file_raddr(file_raddr),
		.file_wr(file_wr),
		.wreg(wreg),
		.flags(flags),
		.phase(phase),
		.busy(busy),
		.done(done)
	);
	// ==========================================
	// Tasks
	task chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask
	task stop_test;
		$display("checks %0d failures %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Runs one instruction and waits for its completion pulse.
	task run(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f,
		input logic [3:0] bp, input logic [7:0] rd, input logic [11:0] ea);
		int n;
		@(posedge clk_sys);
		instr <= {op, d, a, f};
		instr_valid <= 1'b1;
		bank_select_pointer <= bp;
		file_rdata <= rd;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		for (n = 1; n <= 8; n++)
		begin
			@(posedge clk_sys);
			#1;
			if (n == 1)
				chk("mid phase", {busy, phase}, {1'b1, SBNS_Q3});
			if (done === 1'b1)
				break;
		end
		if (n > 8)
		begin
			fail_count++;
			stop_test();
		end
		chk("latency", n, 3);
		chk("file_raddr", file_raddr, ea);
		chk("idle after", {busy, phase}, 3'b000);
		wr_seen = file_wr;
		@(posedge clk_sys);
		#1;
		chk("pulse width", {done, file_wr.we}, 2'b00);
	endtask
	task res(input logic [7:0] w, input logic [4:0] fl, input logic [20:0] wr);
		chk("wreg", wreg, w);
		chk("flags", flags, fl);
		chk("file_wr", wr_seen, wr);
	endtask
	// ==========================================
	// Stimulus
	initial forever #5 clk_sys = ~clk_sys;
	initial
	begin
		logic [1:0] act;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		#1;
		chk("reset state", {wreg, flags, phase, busy}, 16'h0000);
		run(`SBNS_SWAP_OPC, 1'b0, 1'b1, 8'h12, 4'h3, 8'h53, 12'h312);
		res(8'h35, 5'h00, 21'h0);
		run(`SBNS_SWAP_OPC, 1'b0, 1'b1, 8'h34, 4'h3, 8'ha1, 12'h334);
		res(8'h1a, 5'h00, 21'h0);
		run(`SBNS_SUBB_OPC, 1'b0, 1'b0, 8'h90, 4'h3, 8'h1b, 12'hf90);
		res(8'h00, 5'h07, 21'h0);
		run(`SBNS_SWAP_OPC, 1'b0, 1'b0, 8'h10, 4'h3, 8'hd0, 12'h010);
		res(8'h0d, 5'h07, 21'h0);
		run(`SBNS_SUBB_OPC, 1'b1, 1'b0, 8'h05, 4'h3, 8'h19, 12'h005);
		res(8'h0d, 5'h01, {1'b1, 12'h005, 8'h0c});
		run(`SBNS_SWAP_OPC, 1'b0, 1'b1, 8'h20, 4'ha, 8'he0, 12'ha20);
		res(8'h0e, 5'h01, 21'h0);
		run(`SBNS_SUBB_OPC, 1'b1, 1'b1, 8'h03, 4'ha, 8'h03, 12'ha03);
		res(8'h0e, 5'h10, {1'b1, 12'ha03, 8'hf5});
		run(`SBNS_SWAP_OPC, 1'b0, 1'b1, 8'hff, 4'h0, 8'h10, 12'h0ff);
		res(8'h01, 5'h10, 21'h0);
		run(`SBNS_SUBB_OPC, 1'b0, 1'b0, 8'hff, 4'h0, 8'h80, 12'hfff);
		res(8'h7e, 5'h09, 21'h0);
		run(`SBNS_SWAP_OPC, 1'b1, 1'b0, 8'h7f, 4'h5, 8'ha5, 12'h07f);
		res(8'h7e, 5'h09, {1'b1, 12'h07f, 8'h5a});
		act = 2'b00;
		@(posedge clk_sys);
		instr <= {6'h17, 2'b11, 8'h40};
		instr_valid <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk_sys);
			#1;
			act = act | {busy, done};
		end
		chk("unknown opcode", {act, wreg, flags}, {2'b00, 8'h7e, 5'h09});
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		stop_test();
	end
endmodule
